// [rtl/atof_output_format.sv]
// Register read side for acceleration and temperature output bytes.
module atof_output_format #(
  parameter int VARIANT  = atof_pkg::ATOF_VAR_6G_14B,
  parameter bit TEMP_CAL = 1'b1,
  parameter int RAW_W    = 18
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  input  wire logic signed [RAW_W-1:0] acc_raw_x,
  input  wire logic signed [RAW_W-1:0] acc_raw_y,
  input  wire logic signed [RAW_W-1:0] acc_raw_z,
  input  wire logic [atof_pkg::ATOF_TEMP_W-1:0] temp_raw,
  input  wire logic                    checksum_fail,
  input  wire logic                    continuous_selftest_fail,
  input  wire logic                    startup_selftest_fail,
  input  wire logic                    reg_rd_stb,
  input  wire logic [7:0]              reg_addr,
  output logic      [7:0]              reg_rdata,
  output logic                         reg_rvalid,
  output logic                         selftest_alarm_flag
);
  import atof_pkg::*;

  // ==========================================================================
  // Sample formatting
  logic        [15:0] fmt_word [ATOF_AXES];
  logic signed [RAW_W-1:0] raw_axis [ATOF_AXES];
  logic               selftest_fail;

  assign raw_axis[0]   = acc_raw_x;
  assign raw_axis[1]   = acc_raw_y;
  assign raw_axis[2]   = acc_raw_z;
  assign selftest_fail = continuous_selftest_fail | startup_selftest_fail;

  for (genvar g = 0; g < ATOF_AXES; g++) begin : g_axis
    atof_accel_fmt #(
      .VARIANT (VARIANT),
      .RAW_W   (RAW_W)
    ) u_fmt (
      .raw           (raw_axis[g]),
      .checksum_fail (checksum_fail),
      .selftest_fail (selftest_fail),
      .word          (fmt_word[g])
    );
  end

  function automatic logic [7:0] axis_lsb_addr(input int idx);
    axis_lsb_addr = ATOF_ADDR_X_LSB + 8'(idx) * ATOF_ADDR_STEP;
  endfunction

  function automatic logic [7:0] axis_msb_addr(input int idx);
    axis_msb_addr = ATOF_ADDR_X_MSB + 8'(idx) * ATOF_ADDR_STEP;
  endfunction

  // ==========================================================================
  // Output words, holds and read port
  logic [15:0] acc_word      [ATOF_AXES];
  logic [15:0] next_acc_word [ATOF_AXES];
  logic [7:0]  acc_hold      [ATOF_AXES];
  logic [7:0]  next_acc_hold [ATOF_AXES];
  logic [15:0] temp_word;
  logic [15:0] next_temp_word;
  logic [7:0]  temp_hold;
  logic [7:0]  next_temp_hold;
  logic [7:0]  next_reg_rdata;
  logic        next_reg_rvalid;
  logic        next_selftest_alarm_flag;

  always_comb begin
    for (int i = 0; i < ATOF_AXES; i++) begin
      next_acc_word[i] = fmt_word[i];
      next_acc_hold[i] = acc_hold[i];
    end
    if (TEMP_CAL) begin
      // unsigned field at bits 13..1, bits 0 and 15..14 zero
      next_temp_word = {2'b00, temp_raw[ATOF_TEMP_CAL_W-1:0], 1'b0};
    end else begin
      // two's complement field at bits 13..0, bits 15..14 zero
      next_temp_word = {2'b00, temp_raw};
    end
    next_temp_hold           = temp_hold;
    next_reg_rdata           = reg_rdata;
    next_reg_rvalid          = reg_rd_stb;
    next_selftest_alarm_flag = checksum_fail | selftest_fail;
    // The high byte comes from the same registered word that feeds the hold,
    // so the pair always belongs to one sample.
    if (reg_rd_stb) begin
      next_reg_rdata = ATOF_RESET_BYTE;
      for (int i = 0; i < ATOF_AXES; i++) begin
        if (reg_addr == axis_msb_addr(i)) begin
          // axis high byte read latches low byte
          next_reg_rdata   = acc_word[i][15:8];
          next_acc_hold[i] = acc_word[i][7:0];
        end else if (reg_addr == axis_lsb_addr(i)) begin
          next_reg_rdata = acc_hold[i];
        end
      end
      if (reg_addr == ATOF_ADDR_TEMP_MSB) begin
        // high byte out, low byte captured
        next_reg_rdata = temp_word[15:8];
        next_temp_hold = temp_word[7:0];
      end else if (reg_addr == ATOF_ADDR_TEMP_LSB) begin
        // low byte returns the held copy
        next_reg_rdata = temp_hold;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < ATOF_AXES; i++) begin
        acc_word[i] <= ATOF_RESET_WORD;
        acc_hold[i] <= ATOF_RESET_BYTE;
      end
      temp_word           <= ATOF_RESET_WORD;
      temp_hold           <= ATOF_RESET_BYTE;
      reg_rdata           <= ATOF_RESET_BYTE;
      reg_rvalid          <= 1'b0;
      selftest_alarm_flag <= 1'b0;
    end else begin
      for (int i = 0; i < ATOF_AXES; i++) begin
        acc_word[i] <= next_acc_word[i];
        acc_hold[i] <= next_acc_hold[i];
      end
      temp_word           <= next_temp_word;
      temp_hold           <= next_temp_hold;
      reg_rdata           <= next_reg_rdata;
      reg_rvalid          <= next_reg_rvalid;
      selftest_alarm_flag <= next_selftest_alarm_flag;
    end
  end

  // ==========================================================================
  // Checks
  localparam logic [15:0] POS_WORD =
    (VARIANT == ATOF_VAR_6G_12B) ? ATOF_ACC12_POS_WORD :
    (VARIANT == ATOF_VAR_6G_14B) ? ATOF_ACC14_POS_WORD : ATOF_ACC16_POS_WORD;
  localparam logic [15:0] NEG_WORD =
    (VARIANT == ATOF_VAR_6G_12B) ? ATOF_ACC12_NEG_WORD :
    (VARIANT == ATOF_VAR_6G_14B) ? ATOF_ACC14_NEG_WORD : ATOF_ACC16_NEG_WORD;
  localparam logic signed [RAW_W-1:0] RAW_BIG = RAW_W'(40000);

  logic temp_msb_rd;
  logic temp_lsb_rd;
  assign temp_msb_rd = reg_rd_stb && reg_addr == ATOF_ADDR_TEMP_MSB;
  assign temp_lsb_rd = reg_rd_stb && reg_addr == ATOF_ADDR_TEMP_LSB;

  chk_temp_capture: assert property (@(posedge sys_clk) disable iff (!rst_n)
    temp_msb_rd |=> temp_hold == $past(temp_word[7:0]))
    else $error("temperature hold missed the low byte");

  chk_temp_hold_still: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !temp_msb_rd |=> $stable(temp_hold))
    else $error("temperature hold changed without a high byte read");

  chk_temp_lsb_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    temp_lsb_rd |=> reg_rvalid && reg_rdata == $past(temp_hold))
    else $error("low byte read did not return the hold");

  chk_temp_msb_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    temp_msb_rd |=> reg_rdata == $past(temp_word[15:8]))
    else $error("high byte read returned wrong data");

  chk_reset_zero: assert property (@(posedge sys_clk)
    !rst_n |=> reg_rdata == 8'h00 && temp_hold == 8'h00 && !reg_rvalid)
    else $error("registers not zero after reset");

  chk_temp_layout: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rst_n ##1 rst_n |-> temp_word[15:14] == 2'b00 &&
      (TEMP_CAL ? (temp_word[0] == 1'b0 &&
                   temp_word[13:1] == $past(temp_raw[12:0]))
                : temp_word[13:0] == $past(temp_raw)))
    else $error("temperature word layout wrong");

  chk_acc_alarm: assert property (@(posedge sys_clk) disable iff (!rst_n)
    checksum_fail |=> acc_word[0] == 16'h7fff ##0 selftest_alarm_flag)
    else $error("checksum alarm did not force 7fff");

  chk_acc_st_alarm: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !checksum_fail && selftest_fail |=> acc_word[1] == 16'hffff)
    else $error("self-test alarm did not force ffff");

  chk_acc_sat_pos: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !checksum_fail && !selftest_fail && acc_raw_x > RAW_BIG
      |=> acc_word[0] == POS_WORD)
    else $error("positive saturation wrong");

  chk_acc_sat_neg: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !checksum_fail && !selftest_fail && acc_raw_z < -RAW_BIG
      |=> acc_word[2] == NEG_WORD)
    else $error("negative saturation wrong");

  chk_acc_sign_copy: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !checksum_fail && !selftest_fail && VARIANT == ATOF_VAR_6G_14B
      |=> acc_word[0][14] == acc_word[0][15] && acc_word[0][1:0] == 2'b00)
    else $error("sign copy or low bits wrong");

  chk_axis_latch: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_rd_stb && reg_addr == ATOF_ADDR_X_MSB
      ##1 (reg_rd_stb && reg_addr == ATOF_ADDR_X_LSB)
      |=> reg_rdata == $past(acc_word[0][7:0], 2))
    else $error("axis low byte not from the latched sample");

  cov_temp_pair: cover property (@(posedge sys_clk) disable iff (!rst_n)
    temp_msb_rd ##[1:4] temp_lsb_rd);
  cov_axis_read: cover property (@(posedge sys_clk) disable iff (!rst_n)
    reg_rd_stb && reg_addr == ATOF_ADDR_X_MSB ##1 reg_rvalid);
  cov_alarm: cover property (@(posedge sys_clk) disable iff (!rst_n)
    selftest_fail ##1 selftest_alarm_flag);

endmodule

// [rtl/atof_pkg.sv]
// Constants shared by the acceleration and temperature output formatter.
package atof_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] ATOF_ADDR_X_LSB    = 8'h04;
  localparam logic [7:0] ATOF_ADDR_X_MSB    = 8'h05;
  localparam logic [7:0] ATOF_ADDR_STEP     = 8'h02;
  localparam logic [7:0] ATOF_ADDR_TEMP_LSB = 8'h12;
  localparam logic [7:0] ATOF_ADDR_TEMP_MSB = 8'h13;
  localparam logic [7:0] ATOF_RESET_BYTE    = 8'h00;
  localparam logic [15:0] ATOF_RESET_WORD   = 16'h0000;
  localparam int          ATOF_AXES         = 3;

  // ==========================================================================
  // Acceleration variants and limits
  localparam int ATOF_VAR_6G_12B = 0;
  localparam int ATOF_VAR_6G_14B = 1;
  localparam int ATOF_VAR_1G_16B = 2;
  localparam int ATOF_ACC12_MAX  = 2047;
  localparam int ATOF_ACC12_MIN  = -2048;
  localparam int ATOF_ACC14_MAX  = 4095;
  localparam int ATOF_ACC14_MIN  = -4096;
  localparam int ATOF_ACC16_MAX  = 32767;
  localparam int ATOF_ACC16_MIN  = -32768;
  localparam int ATOF_ACC12_LSB  = 4;
  localparam int ATOF_ACC14_LSB  = 2;
  localparam logic [15:0] ATOF_CKS_FAIL_WORD = 16'h7fff;
  localparam logic [15:0] ATOF_ST_FAIL_WORD  = 16'hffff;
  localparam logic [15:0] ATOF_ACC12_POS_WORD = 16'h7ff0;
  localparam logic [15:0] ATOF_ACC12_NEG_WORD = 16'h8000;
  localparam logic [15:0] ATOF_ACC14_POS_WORD = 16'h3ffc;
  localparam logic [15:0] ATOF_ACC14_NEG_WORD = 16'hc000;
  localparam logic [15:0] ATOF_ACC16_POS_WORD = 16'h7fff;
  localparam logic [15:0] ATOF_ACC16_NEG_WORD = 16'h8000;

  // ==========================================================================
  // Temperature field layout
  localparam int ATOF_TEMP_W       = 14;
  localparam int ATOF_TEMP_CAL_W   = 13;
  localparam int ATOF_TEMP_CAL_LSB = 1;

endpackage

// [rtl/atof_accel_fmt.sv]
// Saturation and self-test override for one acceleration output word.
module atof_accel_fmt #(
  parameter int VARIANT = atof_pkg::ATOF_VAR_6G_14B,
  parameter int RAW_W   = 18
) (
  input  wire logic signed [RAW_W-1:0] raw,
  input  wire logic                    checksum_fail,
  input  wire logic                    selftest_fail,
  output logic             [15:0]      word
);
  import atof_pkg::*;

  // ==========================================================================
  // Range limits of the chosen variant
  localparam int LIM_HI_I = (VARIANT == ATOF_VAR_6G_12B) ? ATOF_ACC12_MAX :
                            (VARIANT == ATOF_VAR_6G_14B) ? ATOF_ACC14_MAX :
                                                           ATOF_ACC16_MAX;
  localparam int LIM_LO_I = (VARIANT == ATOF_VAR_6G_12B) ? ATOF_ACC12_MIN :
                            (VARIANT == ATOF_VAR_6G_14B) ? ATOF_ACC14_MIN :
                                                           ATOF_ACC16_MIN;
  localparam logic signed [RAW_W-1:0] LIM_HI = RAW_W'(LIM_HI_I);
  localparam logic signed [RAW_W-1:0] LIM_LO = RAW_W'(LIM_LO_I);

  logic signed [RAW_W-1:0] sat_val;

  // ==========================================================================
  // Formatting
  always_comb begin
    sat_val = raw;
    if (raw > LIM_HI) begin
      sat_val = LIM_HI;
    end else if (raw < LIM_LO) begin
      sat_val = LIM_LO;
    end
    if (checksum_fail) begin
      word = ATOF_CKS_FAIL_WORD;
    end else if (selftest_fail) begin
      word = ATOF_ST_FAIL_WORD;
    end else if (VARIANT == ATOF_VAR_6G_12B) begin
      // twelve bits, low nibble driven to zero.
      word = {sat_val[11:0], 4'h0};
    end else if (VARIANT == ATOF_VAR_6G_14B) begin
      // fourteen bits, bits 1 to 0 driven to zero.
      // bit 14 is a copy of the sign since the value fits 13 bits.
      word = {sat_val[13:0], 2'b00};
    end else begin
      word = sat_val[15:0];
    end
  end

endmodule

// [tb/atof_host_model.sv]
// Host-side model that issues register reads to the output formatter.
module atof_host_model (
  input  wire logic       sys_clk,
  output logic            reg_rd_stb,
  output logic [7:0]      reg_addr,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    reg_rd_stb = 1'b0;
    reg_addr   = 8'h00;
  end

  // ==========================================================================
  // Single register read
  task automatic rd(input logic [7:0] addr, output logic vld,
                    output logic [7:0] data);
    @(posedge sys_clk);
    #1;
    reg_rd_stb = 1'b1;
    reg_addr   = addr;
    @(posedge sys_clk);
    #1;
    reg_rd_stb = 1'b0;
    // A released address flips so the design cannot lean on a stale value.
    reg_addr   = ~addr;
    vld        = reg_rvalid;
    data       = reg_rdata;
  endtask

  // ==========================================================================
  // Word read
  // high byte first
  task automatic rd_word(input logic [7:0] hi_addr, output logic [15:0] w,
                         output logic [1:0] vld);
    @(posedge sys_clk);
    #1;
    reg_rd_stb = 1'b1;
    reg_addr   = hi_addr;
    @(posedge sys_clk);
    #1;
    // The strobe stays up so the low byte read follows back to back.
    reg_addr   = 8'(hi_addr - 8'h01);
    vld[1]     = reg_rvalid;
    w[15:8]    = reg_rdata;
    @(posedge sys_clk);
    #1;
    reg_rd_stb = 1'b0;
    reg_addr   = ~hi_addr;
    vld[0]     = reg_rvalid;
    w[7:0]     = reg_rdata;
  endtask
endmodule

// [tb/accel_temp_output_format_tb_top.sv]
// Self-checking bench for the acceleration and temperature output formatter.
`define CHK(nm, ex, got) begin \
  samples_checked++; \
  if ((got) !== (ex)) begin \
    $display("[ERR] %s expected %h seen %h", nm, ex, got); \
    err_total++; \
  end \
end

module accel_temp_output_format_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import atof_pkg::*;

  logic               sys_clk;
  logic               rst_n;
  logic signed [17:0] acc_raw_x;
  logic signed [17:0] acc_raw_y;
  logic signed [17:0] acc_raw_z;
  logic [13:0]        temp_raw;
  logic [2:0]         fails;
  logic               reg_rd_stb;
  logic [7:0]         reg_addr;
  logic [7:0]         reg_rdata;
  logic               reg_rvalid;
  logic               selftest_alarm_flag;
  logic [7:0]         rdata_v12;
  logic               rvalid_v12;
  logic               alarm_v12;
  logic [7:0]         rdata_v16;
  logic               rvalid_v16;
  logic               alarm_v16;
  int                 err_total = 0;
  int                 samples_checked = 0;

  atof_output_format i_atof_output_format (
    .sys_clk                  (sys_clk),
    .rst_n                    (rst_n),
    .acc_raw_x                (acc_raw_x),
    .acc_raw_y                (acc_raw_y),
    .acc_raw_z                (acc_raw_z),
    .temp_raw                 (temp_raw),
    .checksum_fail            (fails[2]),
    .continuous_selftest_fail (fails[1]),
    .startup_selftest_fail    (fails[0]),
    .reg_rd_stb               (reg_rd_stb),
    .reg_addr                 (reg_addr),
    .reg_rdata                (reg_rdata),
    .reg_rvalid               (reg_rvalid),
    .selftest_alarm_flag      (selftest_alarm_flag)
  );

  // Two more builds of the block cover the other ranges and the
  // uncalibrated temperature format; they share every input.
  atof_output_format #(
    .VARIANT  (ATOF_VAR_6G_12B),
    .TEMP_CAL (1'b0),
    .RAW_W    (18)
  ) i_atof_output_format_v12 (
    .sys_clk                  (sys_clk),
    .rst_n                    (rst_n),
    .acc_raw_x                (acc_raw_x),
    .acc_raw_y                (acc_raw_y),
    .acc_raw_z                (acc_raw_z),
    .temp_raw                 (temp_raw),
    .checksum_fail            (fails[2]),
    .continuous_selftest_fail (fails[1]),
    .startup_selftest_fail    (fails[0]),
    .reg_rd_stb               (reg_rd_stb),
    .reg_addr                 (reg_addr),
    .reg_rdata                (rdata_v12),
    .reg_rvalid               (rvalid_v12),
    .selftest_alarm_flag      (alarm_v12)
  );

  atof_output_format #(
    .VARIANT  (ATOF_VAR_1G_16B),
    .TEMP_CAL (1'b1),
    .RAW_W    (18)
  ) i_atof_output_format_v16 (
    .sys_clk                  (sys_clk),
    .rst_n                    (rst_n),
    .acc_raw_x                (acc_raw_x),
    .acc_raw_y                (acc_raw_y),
    .acc_raw_z                (acc_raw_z),
    .temp_raw                 (temp_raw),
    .checksum_fail            (fails[2]),
    .continuous_selftest_fail (fails[1]),
    .startup_selftest_fail    (fails[0]),
    .reg_rd_stb               (reg_rd_stb),
    .reg_addr                 (reg_addr),
    .reg_rdata                (rdata_v16),
    .reg_rvalid               (rvalid_v16),
    .selftest_alarm_flag      (alarm_v16)
  );

  atof_host_model i_atof_host_model (
    .sys_clk    (sys_clk),
    .reg_rd_stb (reg_rd_stb),
    .reg_addr   (reg_addr),
    .reg_rdata  (reg_rdata),
    .reg_rvalid (reg_rvalid)
  );

  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;

  // ==========================================================================
  // Helpers
  function automatic logic [15:0] exp_acc(input int r, input int hi,
                                          input int lo, input int sh);
    int s;
    s = (r > hi) ? hi : ((r < lo) ? lo : r);
    return 16'(s <<< sh);
  endfunction

  function automatic logic [15:0] exp14(input int r);
    return exp_acc(r, ATOF_ACC14_MAX, ATOF_ACC14_MIN, ATOF_ACC14_LSB);
  endfunction

  task automatic settle;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] ex,
                        input string nm);
    logic       v;
    logic [7:0] d;
    i_atof_host_model.rd(a, v, d);
    `CHK({nm, " valid"}, 1'b1, v)
    `CHK(nm, ex, d)
  endtask

  task automatic word_chk(input logic [7:0] hi, input logic [15:0] ex,
                          input string nm);
    logic [15:0] w;
    logic [1:0]  v;
    i_atof_host_model.rd_word(hi, w, v);
    `CHK({nm, " valid"}, 2'b11, v)
    `CHK(nm, ex, w)
  endtask

  // The other builds answer the same read; their bytes stand until the next.
  task automatic var_chk(input string nm, input logic [7:0] e12,
                         input logic [7:0] e16);
    `CHK({nm, " 12b valid"}, 1'b1, rvalid_v12)
    `CHK({nm, " 12b"}, e12, rdata_v12)
    `CHK({nm, " 16b valid"}, 1'b1, rvalid_v16)
    `CHK({nm, " 16b"}, e16, rdata_v16)
  endtask

  function automatic logic [7:0] axis_hi(input int k);
    return 8'(ATOF_ADDR_X_MSB + ATOF_ADDR_STEP * k);
  endfunction

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    rd_chk(ATOF_ADDR_TEMP_LSB, ATOF_RESET_BYTE, "temp low hold");
    rd_chk(ATOF_ADDR_X_LSB, ATOF_RESET_BYTE, "x low hold");
    rd_chk(8'h30, 8'h00, "unmapped");
  endtask

  task automatic t_temp;
    logic [15:0] w;
    w = {2'b00, temp_raw[12:0], 1'b0};
    rd_chk(ATOF_ADDR_TEMP_MSB, w[15:8], "temp high");
    temp_raw = 14'h0555;
    settle;
    rd_chk(ATOF_ADDR_TEMP_LSB, w[7:0], "temp low held");
    rd_chk(ATOF_ADDR_TEMP_LSB, w[7:0], "temp low again");
    w = {2'b00, temp_raw[12:0], 1'b0};
    word_chk(ATOF_ADDR_TEMP_MSB, w, "temp word");
    temp_raw = 14'h3fff;
    settle;
    word_chk(ATOF_ADDR_TEMP_MSB, 16'h3ffe, "temp word top");
  endtask

  task automatic t_accel;
    int vals[7] = '{5000, -5000, 4095, -4096, 650, -650, 0};
    int ex[3];
    foreach (vals[i]) begin
      ex = '{vals[i], -vals[i], vals[i] / 2};
      acc_raw_x = 18'(ex[0]);
      acc_raw_y = 18'(ex[1]);
      acc_raw_z = 18'(ex[2]);
      settle;
      for (int k = 0; k < ATOF_AXES; k++) begin
        word_chk(axis_hi(k), exp14(ex[k]), "accel word");
      end
    end
    acc_raw_x = 18'(100);
    settle;
    rd_chk(ATOF_ADDR_X_MSB, 8'h01, "x high");
    acc_raw_x = -18'sd3000;
    settle;
    rd_chk(ATOF_ADDR_X_LSB, 8'h90, "x low held");
  endtask

  task automatic t_variants;
    int          vals[4] = '{50000, -90000, 325, -650};
    logic [15:0] e12;
    logic [15:0] e14;
    logic [15:0] e16;
    logic [15:0] wc;
    logic [15:0] wu;
    foreach (vals[i]) begin
      acc_raw_x = 18'(vals[i]);
      acc_raw_z = 18'(-vals[i]);
      settle;
      e12 = exp_acc(vals[i], ATOF_ACC12_MAX, ATOF_ACC12_MIN, ATOF_ACC12_LSB);
      e14 = exp14(vals[i]);
      e16 = exp_acc(vals[i], ATOF_ACC16_MAX, ATOF_ACC16_MIN, 0);
      rd_chk(ATOF_ADDR_X_MSB, e14[15:8], "x high 14b");
      var_chk("x high", e12[15:8], e16[15:8]);
      rd_chk(ATOF_ADDR_X_LSB, e14[7:0], "x low 14b");
      var_chk("x low", e12[7:0], e16[7:0]);
    end
    temp_raw = 14'h2abc;
    wc = {2'b00, temp_raw[12:0], 1'b0};
    wu = {2'b00, temp_raw};
    settle;
    rd_chk(ATOF_ADDR_TEMP_MSB, wc[15:8], "temp high cal");
    var_chk("temp high", wu[15:8], wc[15:8]);
    rd_chk(ATOF_ADDR_TEMP_LSB, wc[7:0], "temp low cal");
    var_chk("temp low", wu[7:0], wc[7:0]);
  endtask

  task automatic t_selftest;
    logic [2:0]  codes[5] = '{3'b100, 3'b110, 3'b010, 3'b001, 3'b000};
    logic [15:0] exw[5] = '{16'h7fff, 16'h7fff, 16'hffff, 16'hffff,
                            16'h0a28};
    acc_raw_x = 18'(650);
    foreach (codes[i]) begin
      fails = codes[i];
      settle;
      `CHK("alarm flag", |codes[i], selftest_alarm_flag)
      `CHK("alarm flag 12b", |codes[i], alarm_v12)
      `CHK("alarm flag 16b", |codes[i], alarm_v16)
      word_chk(ATOF_ADDR_X_MSB, exw[i], "alarm word");
    end
  endtask

  // ==========================================================================
  // Closing report
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // A hung read sequence must still reach the verdict.
  initial begin
    #200us;
    $display("[ERR] run limit expected end seen none");
    err_total++;
    stop_test();
  end

  initial begin
    rst_n     = 1'b0;
    acc_raw_x = '0;
    acc_raw_y = '0;
    acc_raw_z = '0;
    temp_raw  = 14'h1abc;
    fails     = 3'b000;
    repeat (3) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_temp();
    t_accel();
    t_variants();
    t_selftest();
    stop_test();
  end
endmodule
